// ===== rtl/seeld_pkg.sv
package seeld_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TMO_MS = 30;
  localparam int unsigned TMO_CYC = CLK_HZ / 1000 * TMO_MS;
  localparam int unsigned CMD_W = 3;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] SUB_BULK_CLEAR = 2'h2;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam logic [1:0] SUB_FILL_ALL = 2'h1;
  localparam logic [1:0] SIZE_A7 = 2'h0;
  localparam logic [1:0] SIZE_A9 = 2'h1;
  localparam logic [4:0] CLKS_A7 = 5'h0a;
  localparam logic [4:0] CLKS_A9 = 5'h0c;
  localparam logic [4:0] CLKS_A11 = 5'h0e;
  localparam logic [4:0] DATA_CLKS = 5'h08;
  localparam logic [7:0] VALID_FLAG = 8'ha5;
  localparam logic [10:0] ADR_VALID = 11'h000;
  localparam logic [10:0] ADR_STRAP_FLAG = 11'h007;
  localparam logic [10:0] ADR_BURST_FLAG = 11'h00c;
  localparam logic [10:0] ADR_NBURST = 11'h00d;
  localparam logic [7:0] SCK_HALF = 8'h04;
  localparam logic [23:0] TMO_RST = 24'h000000;
  typedef enum logic [2:0] {
    SEELD_CMD_READ = 3'h0,
    SEELD_CMD_WRITE = 3'h1,
    SEELD_CMD_ERASE = 3'h2,
    SEELD_CMD_BULK_CLEAR = 3'h3,
    SEELD_CMD_LOCK = 3'h4,
    SEELD_CMD_UNLOCK = 3'h5,
    SEELD_CMD_FILL_ALL = 3'h6,
    SEELD_CMD_RELOAD = 3'h7
  } seeld_cmd_t;
endpackage : seeld_pkg

// ===== rtl/seeld_sync.sv
`timescale 1ns/100ps
module seeld_sync
  import seeld_pkg::*;
(
  // Clock
  input wire logic i_clk,
  input wire logic i_rst,
  // Level in and out
  input wire logic i_d,
  output logic o_q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end
  assign o_q = q_ff;
endmodule : seeld_sync

// ===== rtl/seeld_link.sv
`timescale 1ns/100ps
module seeld_link
  import seeld_pkg::*;
(
  // Link clock domain
  input wire logic i_lclk,
  input wire logic i_lrst,
  // Request toggle and frame from system domain
  input wire logic i_req_tgl,
  input wire logic [21:0] i_frame,
  input wire logic [4:0] i_nclk,
  // Completion toggle and captured byte
  output logic o_done_tgl,
  output logic [7:0] o_rdata,
  // Serial pins
  output logic o_cs,
  output logic o_sck,
  output logic o_di,
  input wire logic i_do
);
  logic [2:0] req_sync_ff;
  logic [21:0] sh_ff;
  logic [4:0] cnt_ff;
  logic [7:0] half_ff;
  logic run_ff;
  logic sck_ff;
  logic done_ff;
  logic [7:0] rd_ff;
  logic do_meta_ff;
  logic do_ff;
  always_ff @(posedge i_lclk) begin
    if (i_lrst) begin
      req_sync_ff <= 3'h0;
      do_meta_ff <= 1'b0;
      do_ff <= 1'b0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], i_req_tgl};
      do_meta_ff <= i_do;
      do_ff <= do_meta_ff;
    end
  end
  // Chip select covers exactly the counted clocks of one frame
  always_ff @(posedge i_lclk) begin
    if (i_lrst) begin
      run_ff <= 1'b0;
      sck_ff <= 1'b0;
      cnt_ff <= 5'h00;
      half_ff <= 8'h00;
      sh_ff <= 22'h0;
      rd_ff <= 8'h00;
      done_ff <= 1'b0;
    end else if (!run_ff) begin
      if (req_sync_ff[2] != req_sync_ff[1]) begin
        run_ff <= 1'b1;
        sh_ff <= i_frame;
        cnt_ff <= i_nclk;
        half_ff <= 8'h00;
      end
    end else if (half_ff != SCK_HALF) begin
      half_ff <= half_ff + 8'h01;
    end else begin
      half_ff <= 8'h00;
      sck_ff <= ~sck_ff;
      if (sck_ff) begin
        sh_ff <= {sh_ff[20:0], 1'b0};
        cnt_ff <= cnt_ff - 5'h01;
        if (cnt_ff == 5'h01) begin
          run_ff <= 1'b0;
          done_ff <= ~done_ff;
        end
      end else begin
        rd_ff <= {rd_ff[6:0], do_ff};
      end
    end
  end
  assign o_cs = run_ff;
  assign o_sck = sck_ff;
  assign o_di = sh_ff[21];
  assign o_done_tgl = done_ff;
  assign o_rdata = rd_ff;
endmodule : seeld_link

// ===== rtl/seeld_top.sv
// Notes on behaviour
// - Start bit then two-bit opcode
// - Special commands coded in top address bits
// - Seven address bits: 10 or 18 clocks
// - Nine address bits: 12 or 20 clocks
// - Eleven address bits: 14 or 22 clocks
// - Erase one location, 30 ms timeout
// - Bulk clear whole memory, 30 ms timeout
// - Read byte MSB first into data
// - Write data byte, 30 ms timeout
// - Fill every location with data, timeout
// - Loader starts on resets or reload
// - Loader writes system registers via mux
// - Bytes 0 and 12 are A5 flags
// - Bytes 1 to 6 form MAC address
// - Byte 7 strap flag, 8-11 straps, bursts
// - Invalid byte 0: sync PHY, finish
// - Invalid strap flag: read, discard straps
// - Always send all configured address bits
// - Byte 13 burst count, address, count, words
`timescale 1ns/100ps
module seeld_top
  import seeld_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = TMO_CYC
) (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Link clock and reset
  input wire logic i_lclk,
  input wire logic i_lrst,
  // Loader triggers
  input wire logic i_ext_pin_reset,
  input wire logic i_por,
  input wire logic i_digital_reset,
  // Software command port
  input wire logic i_cmd_go,
  input wire logic [2:0] i_cmd,
  input wire logic [10:0] i_eeprom_address_field,
  input wire logic [1:0] i_size_strap,
  input wire logic i_data_we,
  input wire logic [7:0] i_data,
  output logic [7:0] o_eeprom_data_reg,
  output logic o_eeprom_busy_flag,
  output logic o_eeprom_timeout_flag,
  input wire logic i_timeout_clr,
  // Loader outputs
  output logic [31:0] o_mac_lo,
  output logic [31:0] o_mac_hi,
  output logic [31:0] o_straps,
  output logic o_straps_valid,
  output logic o_phy_sync,
  output logic o_csr_we,
  output logic [9:0] o_csr_addr,
  output logic [31:0] o_csr_data,
  // Serial pins
  output logic o_ee_cs,
  output logic o_ee_sck,
  output logic o_ee_di,
  input wire logic i_ee_do
);
  typedef enum logic [3:0] {
    SEELD_IDLE = 4'h0, SEELD_SEND = 4'h1, SEELD_WAITF = 4'h3,
    SEELD_POLL = 4'h2, SEELD_LD_NEXT = 4'h6, SEELD_LD_READ = 4'h7,
    SEELD_LD_WAIT = 4'h5, SEELD_LD_DONE = 4'h4
  } seeld_state_t;
  seeld_state_t state_ff;
  logic req_tgl_ff;
  logic [21:0] frame_ff;
  logic [4:0] nclk_ff;
  logic done_tgl;
  logic [7:0] link_rdata;
  logic [2:1] done_ff;
  logic done_sync;
  logic done_evt;
  logic rdy_sync;
  logic [7:0] data_ff;
  logic busy_ff;
  logic tmo_ff;
  logic [23:0] tmo_cnt_ff;
  logic [2:0] cur_cmd_ff;
  logic loading_ff;
  logic [10:0] ld_adr_ff;
  logic [7:0] nburst_ff;
  logic [7:0] wcnt_ff;
  logic [1:0] bpos_ff;
  logic [3:0] hdr_ff;
  logic strap_ok_ff;
  logic [31:0] mac_lo_ff;
  logic [31:0] mac_hi_ff;
  logic [31:0] straps_ff;
  logic straps_valid_ff;
  logic phy_sync_ff;
  logic csr_we_ff;
  logic [9:0] csr_addr_ff;
  logic [31:0] csr_data_ff;
  logic [2:0] trig_sync;
  logic [2:0] trig_prev_ff;
  logic trig_evt;
  logic [4:0] base_clks;
  logic [1:0] sub;
  logic has_data;
  logic needs_poll;
  logic [1:0] opc;
  logic [10:0] adr;
  logic [7:0] b;

  seeld_link u_link (
    .i_lclk(i_lclk), .i_lrst(i_lrst), .i_req_tgl(req_tgl_ff),
    .i_frame(frame_ff), .i_nclk(nclk_ff), .o_done_tgl(done_tgl),
    .o_rdata(link_rdata), .o_cs(o_ee_cs), .o_sck(o_ee_sck),
    .o_di(o_ee_di), .i_do(i_ee_do)
  );
  seeld_sync u_done_sync (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(done_tgl), .o_q(done_sync)
  );
  seeld_sync u_rdy_sync (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(i_ee_do), .o_q(rdy_sync)
  );
  seeld_sync u_t0 (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(i_ext_pin_reset), .o_q(trig_sync[0])
  );
  seeld_sync u_t1 (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(i_por), .o_q(trig_sync[1])
  );
  seeld_sync u_t2 (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(i_digital_reset), .o_q(trig_sync[2])
  );
  assign done_evt = done_ff[1] != done_ff[2];
  // Loader triggered on release of any reset source
  assign trig_evt = |(trig_prev_ff & ~trig_sync);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_ff[2:1] <= 2'h0;
      trig_prev_ff <= 3'h0;
    end else begin
      done_ff[2:1] <= {done_ff[1], done_sync};
      trig_prev_ff <= trig_sync;
    end
  end

  // Frame assembly for the command in hand
  always_comb begin
    sub = SUB_LOCK;
    has_data = 1'b0;
    needs_poll = 1'b1;
    opc = OP_SPECIAL;
    adr = i_eeprom_address_field;
    case (i_size_strap)
      SIZE_A7: base_clks = CLKS_A7;
      SIZE_A9: base_clks = CLKS_A9;
      default: base_clks = CLKS_A11;
    endcase
    case (seeld_cmd_t'(i_cmd))
      SEELD_CMD_READ: begin
        opc = OP_READ;
        has_data = 1'b1;
        needs_poll = 1'b0;
      end
      SEELD_CMD_WRITE: begin
        opc = OP_WRITE;
        has_data = 1'b1;
      end
      SEELD_CMD_ERASE: opc = OP_ERASE;
      SEELD_CMD_BULK_CLEAR: sub = SUB_BULK_CLEAR;
      SEELD_CMD_FILL_ALL: begin
        sub = SUB_FILL_ALL;
        has_data = 1'b1;
      end
      SEELD_CMD_UNLOCK: begin
        sub = SUB_UNLOCK;
        needs_poll = 1'b0;
      end
      default: needs_poll = 1'b0;
    endcase
    if (opc == OP_SPECIAL) begin
      // Special code sits in the two top address bits
      case (i_size_strap)
        SIZE_A7: adr = {4'h0, sub, 5'h00};
        SIZE_A9: adr = {2'h0, sub, 7'h00};
        default: adr = {sub, 9'h000};
      endcase
    end
    if (has_data) begin
      base_clks = base_clks + DATA_CLKS;
    end
  end

  // Command and loader sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= SEELD_IDLE;
      req_tgl_ff <= 1'b0;
      frame_ff <= 22'h0;
      nclk_ff <= 5'h00;
      busy_ff <= 1'b0;
      cur_cmd_ff <= 3'h0;
      loading_ff <= 1'b0;
      ld_adr_ff <= 11'h000;
      tmo_cnt_ff <= TMO_RST;
    end else begin
      case (state_ff)
        SEELD_IDLE: begin
          if (trig_evt || (i_cmd_go && i_cmd == SEELD_CMD_RELOAD)) begin
            busy_ff <= 1'b1;
            loading_ff <= 1'b1;
            ld_adr_ff <= ADR_VALID;
            state_ff <= SEELD_LD_READ;
          end else if (i_cmd_go) begin
            busy_ff <= 1'b1;
            cur_cmd_ff <= i_cmd;
            nclk_ff <= base_clks;
            // Left-aligned: start, opcode, address, data
            case (i_size_strap)
              SIZE_A7: frame_ff <= {1'b1, opc, adr[6:0], data_ff, 4'h0};
              SIZE_A9: frame_ff <= {1'b1, opc, adr[8:0], data_ff, 2'h0};
              default: frame_ff <= {1'b1, opc, adr, data_ff};
            endcase
            state_ff <= SEELD_SEND;
          end
        end
        SEELD_SEND: begin
          req_tgl_ff <= ~req_tgl_ff;
          state_ff <= SEELD_WAITF;
        end
        SEELD_WAITF: begin
          tmo_cnt_ff <= TMO_RST;
          if (done_evt) begin
            if (loading_ff) state_ff <= SEELD_LD_NEXT;
            else if (cur_cmd_ff == SEELD_CMD_WRITE ||
                     cur_cmd_ff == SEELD_CMD_ERASE ||
                     cur_cmd_ff == SEELD_CMD_BULK_CLEAR ||
                     cur_cmd_ff == SEELD_CMD_FILL_ALL) begin
              state_ff <= SEELD_POLL;
            end else begin
              busy_ff <= 1'b0;
              state_ff <= SEELD_IDLE;
            end
          end
        end
        SEELD_POLL: begin
          tmo_cnt_ff <= tmo_cnt_ff + 24'h000001;
          if (rdy_sync || tmo_cnt_ff >= 24'(TMO_CYCLES - 1)) begin
            busy_ff <= 1'b0;
            state_ff <= SEELD_IDLE;
          end
        end
        SEELD_LD_READ: begin
          case (i_size_strap)
            SIZE_A7: frame_ff <= {1'b1, OP_READ, ld_adr_ff[6:0], 12'h000};
            SIZE_A9: frame_ff <= {1'b1, OP_READ, ld_adr_ff[8:0], 10'h000};
            default: frame_ff <= {1'b1, OP_READ, ld_adr_ff, 8'h00};
          endcase
          // Loader length follows the strap only, whatever i_cmd holds
          case (i_size_strap)
            SIZE_A7: nclk_ff <= CLKS_A7 + DATA_CLKS;
            SIZE_A9: nclk_ff <= CLKS_A9 + DATA_CLKS;
            default: nclk_ff <= CLKS_A11 + DATA_CLKS;
          endcase
          state_ff <= SEELD_SEND;
        end
        SEELD_LD_NEXT: begin
          ld_adr_ff <= ld_adr_ff + 11'h001;
          state_ff <= SEELD_LD_READ;
          if ((ld_adr_ff == ADR_VALID && link_rdata != VALID_FLAG) ||
              (ld_adr_ff == ADR_BURST_FLAG && link_rdata != VALID_FLAG) ||
              (ld_adr_ff == ADR_NBURST && link_rdata == 8'h00) ||
              (ld_adr_ff > ADR_NBURST && hdr_ff == 4'h1 &&
               link_rdata == 8'h00 && nburst_ff == 8'h01) ||
              (ld_adr_ff > ADR_NBURST && hdr_ff == 4'h0 &&
               bpos_ff == 2'h3 && wcnt_ff == 8'h01 &&
               nburst_ff == 8'h01)) begin
            state_ff <= SEELD_LD_DONE;
          end
        end
        default: begin
          busy_ff <= 1'b0;
          loading_ff <= 1'b0;
          state_ff <= SEELD_IDLE;
        end
      endcase
    end
  end

  // Loader: byte routing by EEPROM address
  assign b = link_rdata;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mac_lo_ff <= 32'h00000000;
      mac_hi_ff <= 32'h00000000;
      straps_ff <= 32'h00000000;
      straps_valid_ff <= 1'b0;
      strap_ok_ff <= 1'b0;
      phy_sync_ff <= 1'b0;
      nburst_ff <= 8'h00;
      wcnt_ff <= 8'h00;
      bpos_ff <= 2'h0;
      hdr_ff <= 4'h0;
      csr_we_ff <= 1'b0;
      csr_addr_ff <= 10'h000;
      csr_data_ff <= 32'h00000000;
    end else begin
      csr_we_ff <= 1'b0;
      phy_sync_ff <= 1'b0;
      if (state_ff == SEELD_LD_NEXT) begin
        if (ld_adr_ff == ADR_VALID) begin
          if (b != VALID_FLAG) phy_sync_ff <= 1'b1;
        end else if (ld_adr_ff < ADR_STRAP_FLAG) begin
          // Network byte order into low then high word
          if (ld_adr_ff < 11'h005)
            mac_lo_ff[8*2'(ld_adr_ff[1:0] - 2'h1) +: 8] <= b;
          else
            mac_hi_ff[8*(ld_adr_ff[0] ? 0 : 1) +: 8] <= b;
        end else if (ld_adr_ff == ADR_STRAP_FLAG) begin
          strap_ok_ff <= (b == VALID_FLAG);
        end else if (ld_adr_ff < ADR_BURST_FLAG) begin
          if (strap_ok_ff) begin
            straps_ff[8*(ld_adr_ff[1:0]) +: 8] <= b;
          end
          if (ld_adr_ff == 11'h00b) begin
            straps_valid_ff <= strap_ok_ff;
            phy_sync_ff <= 1'b1;
          end
        end else if (ld_adr_ff == ADR_NBURST) begin
          nburst_ff <= b;
          hdr_ff <= 4'h2;
        end else if (ld_adr_ff > ADR_NBURST) begin
          if (hdr_ff == 4'h2) begin
            csr_addr_ff <= {b, 2'h0};
            hdr_ff <= 4'h1;
          end else if (hdr_ff == 4'h1) begin
            wcnt_ff <= b;
            bpos_ff <= 2'h0;
            hdr_ff <= (b == 8'h00) ? 4'h2 : 4'h0;
            if (b == 8'h00) nburst_ff <= nburst_ff - 8'h01;
          end else begin
            csr_data_ff <= {csr_data_ff[23:0], b};
            bpos_ff <= bpos_ff + 2'h1;
            if (bpos_ff == 2'h3) begin
              csr_we_ff <= 1'b1;
              wcnt_ff <= wcnt_ff - 8'h01;
              if (wcnt_ff == 8'h01) begin
                hdr_ff <= 4'h2;
                nburst_ff <= nburst_ff - 8'h01;
              end
            end
          end
        end
      end
      if (csr_we_ff) csr_addr_ff <= csr_addr_ff + 10'h004;
    end
  end

  // Data register: software write or read result
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_ff <= 8'h00;
    end else if (state_ff == SEELD_WAITF && done_evt && !loading_ff &&
                 cur_cmd_ff == SEELD_CMD_READ) begin
      data_ff <= link_rdata;
    end else if (i_data_we && state_ff == SEELD_IDLE) begin
      data_ff <= i_data;
    end
  end

  // Timeout flag: hardware set wins over software clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tmo_ff <= 1'b0;
    end else if (state_ff == SEELD_POLL && !rdy_sync &&
                 tmo_cnt_ff >= 24'(TMO_CYCLES - 1)) begin
      tmo_ff <= 1'b1;
    end else if (i_timeout_clr) begin
      tmo_ff <= 1'b0;
    end
  end

  assign o_eeprom_data_reg = data_ff;
  assign o_eeprom_busy_flag = busy_ff;
  assign o_eeprom_timeout_flag = tmo_ff;
  assign o_mac_lo = mac_lo_ff;
  assign o_mac_hi = mac_hi_ff;
  assign o_straps = straps_ff;
  assign o_straps_valid = straps_valid_ff;
  assign o_phy_sync = phy_sync_ff;
  assign o_csr_we = csr_we_ff;
  assign o_csr_addr = csr_addr_ff;
  assign o_csr_data = csr_data_ff;

  a_busy_on_go: assert property (@(posedge i_clk) disable iff (i_rst)
    state_ff == SEELD_IDLE && i_cmd_go |=> busy_ff)
    else $error("busy not raised");
  a_poll_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    state_ff == SEELD_POLL && rdy_sync |=> !busy_ff)
    else $error("ready not taken");
  a_tmo_stick: assert property (@(posedge i_clk) disable iff (i_rst)
    tmo_ff && !i_timeout_clr |=> tmo_ff)
    else $error("timeout lost");
  a_send_toggles: assert property (@(posedge i_clk) disable iff (i_rst)
    state_ff == SEELD_SEND |=> req_tgl_ff != $past(req_tgl_ff))
    else $error("frame not launched");
  a_start_bit: assert property (@(posedge i_clk) disable iff (i_rst)
    state_ff == SEELD_SEND |-> frame_ff[21])
    else $error("start bit missing");
  a_read_clks: assert property (@(posedge i_clk) disable iff (i_rst)
    state_ff == SEELD_SEND && i_size_strap == SIZE_A7 && loading_ff
    |-> nclk_ff == 5'h12)
    else $error("read clocks wrong");
  a_load_busy: assert property (@(posedge i_clk) disable iff (i_rst)
    loading_ff |-> busy_ff)
    else $error("loader not busy");
  a_csr_once: assert property (@(posedge i_clk) disable iff (i_rst)
    csr_we_ff |=> !csr_we_ff)
    else $error("double csr write");
endmodule : seeld_top

// ===== verif/seeld_ee_model.sv
`timescale 1ns/100ps
module seeld_ee_model (
  // Serial pins
  input wire logic i_cs,
  input wire logic i_sck,
  input wire logic i_di,
  output logic o_do,
  // Bench controls
  input wire logic [3:0] i_abits,
  input wire logic i_stall
);
  logic [7:0] mem [0:2047];
  logic b [0:31];
  logic unl;
  logic prg;
  logic st;
  logic [1:0] op;
  logic [10:0] a;
  logic [7:0] d;
  int cnt;
  int nclk;
  int nfr;

  function automatic logic [10:0] fld(input int lo, input int n);
    logic [10:0] v;
    v = 11'h000;
    for (int i = 0; i < n; i++) v = {v[9:0], b[lo + i]};
    return v;
  endfunction : fld

  initial begin
    o_do = 1'b1;
    unl = 1'b0;
    nfr = 0;
    cnt = 0;
    foreach (mem[i]) mem[i] = 8'hff;
  end

  always @(posedge i_cs) cnt = 0;

  // Toggled on every clock of the command bits, so the line wanders
  always @(posedge i_sck) begin
    if (i_cs) begin
      if (cnt < 32) b[cnt] = i_di;
      cnt = cnt + 1;
      if (cnt <= 3 + i_abits) o_do = ~o_do;
    end
  end

  // Read data leaves on the falling clock, msb first
  always @(negedge i_sck) begin
    if (i_cs && b[1] && !b[2] && cnt >= 3 + i_abits && cnt < 11 + i_abits)
      o_do = mem[fld(3, i_abits)][10 + i_abits - cnt];
  end

  always @(negedge i_cs) begin
    nclk = cnt;
    nfr = nfr + 1;
    st = b[0];
    op = {b[1], b[2]};
    a = fld(3, i_abits);
    d = 8'(fld(3 + i_abits, 8));
    prg = op == 2'b01 || op == 2'b11 || (op == 2'b00 && b[3] != b[4]);
    case (op)
      2'b01: if (unl) mem[a] = d;
      2'b11: if (unl) mem[a] = 8'hff;
      2'b00: begin
        if (unl && b[3] && !b[4]) foreach (mem[i]) mem[i] = 8'hff;
        if (unl && !b[3] && b[4]) foreach (mem[i]) mem[i] = d;
        if (b[3] == b[4]) unl = b[3];
      end
      default: ;
    endcase
    if (prg && unl) begin
      // Busy while the cells program, then ready unless told to stall
      o_do = 1'b0;
      #150;
      wait (!i_stall);
      o_do = 1'b1;
    end else if (prg) begin
      o_do = 1'b1;
    end else begin
      o_do = ~o_do;
    end
  end
endmodule : seeld_ee_model

// ===== verif/tb_seeld_top.sv
`timescale 1ns/100ps
module tb_seeld_top
  import seeld_pkg::*;
;
  typedef struct packed {
    logic [1:0] sz;
    seeld_cmd_t cmd;
    logic [10:0] ad;
    logic [7:0] dt;
    logic [7:0] rx;
  } seeld_row_t;

  localparam logic [7:0] IMG [0:19] = '{8'ha5, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h15, 8'h16, 8'ha5, 8'h21, 8'h22, 8'h23, 8'h24, 8'ha5, 8'h01, 8'h10,
    8'h01, 8'ha1, 8'ha2, 8'ha3, 8'ha4};
  localparam seeld_cmd_t TC [0:3] = '{SEELD_CMD_ERASE, SEELD_CMD_BULK_CLEAR,
    SEELD_CMD_WRITE, SEELD_CMD_FILL_ALL};

  logic i_clk, i_rst, i_lclk, i_lrst, i_ext_pin_reset, i_por, i_digital_reset;
  logic i_cmd_go, i_data_we, i_timeout_clr, i_ee_do, stall;
  seeld_cmd_t i_cmd;
  logic [10:0] i_eeprom_address_field;
  logic [1:0] i_size_strap;
  logic [7:0] i_data, o_eeprom_data_reg;
  logic o_eeprom_busy_flag, o_eeprom_timeout_flag, o_straps_valid, o_phy_sync;
  logic [31:0] o_mac_lo, o_mac_hi, o_straps, o_csr_data, csr_d;
  logic o_csr_we, o_ee_cs, o_ee_sck, o_ee_di;
  logic [9:0] o_csr_addr, csr_a;
  logic [3:0] abits;
  int n_fail = 0;
  int checks = 0;
  int ncsr = 0;
  int nphy = 0;
  int wk, n, np;
  seeld_row_t rows [0:13];

  assign abits = (i_size_strap == 2'h0) ? 4'h7 :
                 (i_size_strap == 2'h1) ? 4'h9 : 4'hb;

  seeld_top #(.TMO_CYCLES(200)) u_dut (.*);

  seeld_ee_model u_ee (.i_cs(o_ee_cs), .i_sck(o_ee_sck), .i_di(o_ee_di),
    .o_do(i_ee_do), .i_abits(abits), .i_stall(stall));

  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;
  initial begin
    i_lclk = 1'b0;
    #1.3;
    forever #3 i_lclk = ~i_lclk;
  end

  always @(posedge i_clk) begin
    if (o_csr_we === 1'b1) begin
      ncsr <= ncsr + 1;
      csr_a <= o_csr_addr;
      csr_d <= o_csr_data;
    end
    if (o_phy_sync === 1'b1) nphy <= nphy + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic wait_busy();
    wk = 0;
    while (o_eeprom_busy_flag !== 1'b1 && wk < 40) begin
      @(negedge i_clk);
      wk++;
    end
    chk(wk < 40, 1);
    wk = 0;
    while (o_eeprom_busy_flag !== 1'b0 && wk < 20000) begin
      @(negedge i_clk);
      wk++;
    end
    chk(wk < 20000, 1);
  endtask : wait_busy

  task automatic go(input seeld_cmd_t c, input int k);
    i_cmd = c;
    i_cmd_go = 1'b1;
    repeat (k) @(negedge i_clk);
    i_cmd_go = 1'b0;
    wait_busy();
  endtask : go

  task automatic run_row(input seeld_row_t r);
    int m;
    logic [1:0] eo, es;
    m = u_ee.nfr;
    eo = 2'b00;
    es = 2'b00;
    case (r.cmd)
      SEELD_CMD_READ: eo = 2'b10;
      SEELD_CMD_WRITE: eo = 2'b01;
      SEELD_CMD_ERASE: eo = 2'b11;
      SEELD_CMD_BULK_CLEAR: es = 2'b10;
      SEELD_CMD_UNLOCK: es = 2'b11;
      SEELD_CMD_FILL_ALL: es = 2'b01;
      default: es = 2'b00;
    endcase
    i_size_strap = r.sz;
    i_eeprom_address_field = r.ad;
    i_data = r.dt;
    i_data_we = 1'b1;
    @(negedge i_clk);
    i_data_we = 1'b0;
    go(r.cmd, 1);
    chk(u_ee.st, 1);
    chk(u_ee.op, eo);
    chk(u_ee.nclk, 3 + abits + ((eo[0] ^ eo[1]) || es == 2'b01 ? 8 : 0));
    if (eo == 2'b00) chk({u_ee.b[3], u_ee.b[4]}, es);
    else chk(u_ee.a, r.ad & ((11'h1 << abits) - 11'h1));
    if (eo == 2'b10) chk(o_eeprom_data_reg, r.rx);
    if (eo == 2'b01 || es == 2'b01) chk(u_ee.d, r.dt);
    chk(u_ee.nfr, m + 1);
  endtask : run_row

  initial begin
    #800000;
    n_fail = n_fail + 1;
    close_out();
  end

  initial begin
    {i_rst, i_lrst, i_por, i_ext_pin_reset, i_digital_reset} = 5'h1c;
    {i_cmd_go, i_data_we, i_timeout_clr, stall} = 4'h0;
    i_cmd = SEELD_CMD_READ;
    i_eeprom_address_field = 11'h000;
    i_size_strap = 2'h0;
    i_data = 8'h00;
    rows = '{'{2'h0, SEELD_CMD_UNLOCK, 11'h000, 8'h00, 8'h00},
      '{2'h0, SEELD_CMD_WRITE, 11'h005, 8'h3c, 8'h00},
      '{2'h0, SEELD_CMD_READ, 11'h005, 8'h00, 8'h3c},
      '{2'h1, SEELD_CMD_WRITE, 11'h1aa, 8'h96, 8'h00},
      '{2'h1, SEELD_CMD_READ, 11'h1aa, 8'h00, 8'h96},
      '{2'h1, SEELD_CMD_ERASE, 11'h005, 8'h00, 8'h00},
      '{2'h0, SEELD_CMD_READ, 11'h005, 8'h00, 8'hff},
      '{2'h2, SEELD_CMD_FILL_ALL, 11'h000, 8'h5a, 8'h00},
      '{2'h2, SEELD_CMD_READ, 11'h7ff, 8'h00, 8'h5a},
      '{2'h3, SEELD_CMD_BULK_CLEAR, 11'h000, 8'h00, 8'h00},
      '{2'h3, SEELD_CMD_READ, 11'h4c3, 8'h00, 8'hff},
      '{2'h2, SEELD_CMD_LOCK, 11'h000, 8'h00, 8'h00},
      '{2'h2, SEELD_CMD_WRITE, 11'h009, 8'h11, 8'h00},
      '{2'h1, SEELD_CMD_READ, 11'h009, 8'h00, 8'hff}};
    repeat (2) @(negedge i_clk);
    {i_rst, i_lrst} = 2'h0;
    // Power-on level outlasts the block reset so its release is seen
    repeat (3) @(negedge i_clk);
    i_por = 1'b0;
    wait_busy();
    chk(nphy, 1);
    chk(ncsr, 0);
    $display("test power-up done");
    foreach (rows[i]) run_row(rows[i]);
    chk(o_eeprom_timeout_flag, 0);
    $display("test rows done");
    n = u_ee.nfr;
    go(SEELD_CMD_READ, 2);
    chk(u_ee.nfr, n + 1);
    $display("test refusal done");
    go(SEELD_CMD_UNLOCK, 1);
    foreach (TC[i]) begin
      stall = 1'b1;
      go(TC[i], 1);
      chk(o_eeprom_timeout_flag, 1);
      chk(wk >= 200 && wk < 400, 1);
      stall = 1'b0;
      i_timeout_clr = 1'b1;
      @(negedge i_clk);
      i_timeout_clr = 1'b0;
      @(negedge i_clk);
      chk(o_eeprom_timeout_flag, 0);
    end
    $display("test timeout done");
    i_size_strap = 2'h0;
    foreach (IMG[i]) u_ee.mem[i] = IMG[i];
    for (int t = 0; t < 4; t++) begin
      if (t == 2) {u_ee.mem[7], u_ee.mem[8], u_ee.mem[12]} = 24'h0;
      if (t == 3) u_ee.mem[0] = 8'h00;
      n = ncsr;
      np = nphy;
      case (t)
        0: go(SEELD_CMD_RELOAD, 1);
        1: i_digital_reset = 1'b1;
        2: i_ext_pin_reset = 1'b1;
        default: i_por = 1'b1;
      endcase
      if (t > 0) begin
        repeat (2) @(negedge i_clk);
        {i_digital_reset, i_ext_pin_reset, i_por} = 3'h0;
        wait_busy();
      end
      chk(nphy, np + 1);
      chk(ncsr, n + (t < 2 ? 1 : 0));
      if (t < 3) begin
        chk(o_mac_lo, 32'h14131211);
        chk(o_mac_hi, 32'h00001615);
        chk(csr_a, 10'h040);
        chk(csr_d, 32'ha1a2a3a4);
        chk(o_straps, 32'h24232221);
        chk(o_straps_valid, t < 2);
      end
    end
    $display("test loader done");
    close_out();
  end
endmodule : tb_seeld_top
